/* logic/saer_pkg.sv */
// Shared constants of the servo amplifier error recovery block
package saer_pkg;
    localparam int          NUM_AXES       = 16;
    localparam int          LOG_DEPTH      = 8;
    localparam int          CODE_W         = 32;
    localparam int          BCD_W          = 8;
    localparam int          SUB_W          = 4;
    localparam int          CNT_W          = 8;
    // Amplifier group prefix sits in the upper half of the code
    localparam logic [31:0] AMP_GROUP_BASE = 32'h00FF_0000;
    localparam logic [7:0]  BCD_TEN        = 8'h0A;
    localparam logic [7:0]  CNT_MAX        = 8'hFF;
    // Codes for unit-level faults; values are arbitrary
    localparam logic [31:0] SYS_FAULT_CODE = 32'h0000_1001;
    localparam logic [31:0] AMP_LINK_CODE  = 32'h0000_1002;
    localparam logic [31:0] RESET_CODE     = 32'h0000_0000;
endpackage

/* logic/saer_code_if.sv */
// Carrier between the error unit and the alarm code converter
`timescale 1ns/10ps
interface saer_code_if;
    logic [saer_pkg::BCD_W-1:0]  main_bcd;
    logic [saer_pkg::CODE_W-1:0] code;
    modport conv (input main_bcd, output code);
    modport user (output main_bcd, input code);
endinterface

/* logic/saer_code_conv.sv */
// Decimal main alarm number to amplifier group error code
`timescale 1ns/10ps
module saer_code_conv (
    saer_code_if.conv cif
);
    logic [7:0] tens;
    logic [7:0] ones;
    logic [7:0] bin;

    always_comb begin
        tens = {4'h0, cif.main_bcd[7:4]};
        ones = {4'h0, cif.main_bcd[3:0]};
        bin  = 8'(tens * saer_pkg::BCD_TEN) + ones;
        // Hex value in the low 16 bits, group prefix above
        cif.code = saer_pkg::AMP_GROUP_BASE | {16'h0000, 8'h00, bin};
    end
endmodule

/* logic/saer_error_unit.sv */
// Per-axis error capture, halt, servo release and error log
`timescale 1ns/10ps
module saer_error_unit #(
    parameter int NUM_AXES = saer_pkg::NUM_AXES,
    parameter int AW       = $clog2(NUM_AXES)
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rstn,
    input  wire logic                         amp_valid,
    input  wire logic [AW-1:0]                amp_axis,
    input  wire logic [saer_pkg::BCD_W-1:0]   amp_main_bcd,
    input  wire logic [saer_pkg::SUB_W-1:0]   amp_sub,
    input  wire logic                         amp_link_lost,
    input  wire logic [AW-1:0]                amp_link_axis,
    input  wire logic                         sys_fault,
    input  wire logic                         err_valid,
    input  wire logic [AW-1:0]                err_axis,
    input  wire logic [saer_pkg::CODE_W-1:0]  err_code,
    input  wire logic [NUM_AXES-1:0]          err_clr_req,
    input  wire logic [NUM_AXES-1:0]          servo_on_req,
    input  wire logic [NUM_AXES-1:0]          servo_off_req,
    input  wire logic [AW-1:0]                rd_axis,
    input  wire logic [2:0]                   rd_slot,
    output logic [NUM_AXES-1:0]               axis_error,
    output logic [NUM_AXES-1:0]               axis_halt,
    output logic [NUM_AXES-1:0]               axis_locked,
    output logic                              unrecoverable,
    output logic [NUM_AXES-1:0]               servo_active,
    output logic [NUM_AXES-1:0]               servo_free,
    output logic [saer_pkg::CODE_W-1:0]       rd_code,
    output logic [NUM_AXES-1:0][saer_pkg::CNT_W-1:0] err_count
);
    localparam int LD = saer_pkg::LOG_DEPTH;
    localparam int CW = saer_pkg::CODE_W;

    typedef struct packed {
        logic [NUM_AXES-1:0]                       err;
        logic [NUM_AXES-1:0]                       lock;
        logic [NUM_AXES-1:0]                       servo;
        logic                                      sys_lock;
        logic [NUM_AXES-1:0][saer_pkg::CNT_W-1:0]  cnt;
        logic [NUM_AXES-1:0][LD-1:0][CW-1:0]       log;
        logic [CW-1:0]                             rd_code;
    } saer_state_t;

    saer_state_t st_ff;
    saer_state_t nxt_st;
    saer_code_if cif ();

    ////////////////////////////////////////////////////////////////////
    // Alarm conversion; sub code never enters the code path
    assign cif.main_bcd = amp_main_bcd;

    saer_code_conv u_conv (
        .cif (cif)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic sel_link;
        logic sel_amp;
        logic sel_oth;
        logic hit;
        logic [CW-1:0] code;
        sel_link = 1'b0;
        sel_amp  = 1'b0;
        sel_oth  = 1'b0;
        hit      = 1'b0;
        code     = saer_pkg::RESET_CODE;
        nxt_st   = st_ff;
        if (sys_fault) begin
            nxt_st.sys_lock = 1'b1;
        end
        for (int a = 0; a < NUM_AXES; a++) begin
            sel_link = amp_link_lost && (amp_link_axis == AW'(a));
            sel_amp  = amp_valid && (amp_axis == AW'(a));
            sel_oth  = err_valid && (err_axis == AW'(a));
            hit      = sys_fault || sel_link || sel_amp || sel_oth;
            // Priority: unit fault, link loss, alarm, other
            if (sys_fault) begin
                code = saer_pkg::SYS_FAULT_CODE;
            end else if (sel_link) begin
                code = saer_pkg::AMP_LINK_CODE;
            end else if (sel_amp) begin
                code = cif.code;
            end else begin
                code = err_code;
            end
            if (hit) begin
                // New event wins over a clear in the same cycle
                nxt_st.err[a] = 1'b1;
                nxt_st.log[a][LD-1:1] = st_ff.log[a][LD-2:0];
                nxt_st.log[a][0] = code;
                if (st_ff.cnt[a] != saer_pkg::CNT_MAX) begin
                    nxt_st.cnt[a] = st_ff.cnt[a] + 8'h01;
                end
            end else if (err_clr_req[a] && !st_ff.lock[a]
                         && !st_ff.sys_lock) begin
                nxt_st.err[a] = 1'b0;
            end
            if (sys_fault || sel_link) begin
                nxt_st.lock[a] = 1'b1;
            end
            // Only a fresh request re-powers the axis
            if (sys_fault || sel_link || sel_amp) begin
                nxt_st.servo[a] = 1'b0;
            end else if (servo_off_req[a]) begin
                nxt_st.servo[a] = 1'b0;
            end else if (servo_on_req[a] && !st_ff.err[a] && !hit) begin
                nxt_st.servo[a] = 1'b1;
            end
        end
        nxt_st.rd_code = st_ff.log[rd_axis][rd_slot];
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign axis_error    = st_ff.err;
    assign axis_halt     = st_ff.err;
    assign axis_locked   = st_ff.lock | {NUM_AXES{st_ff.sys_lock}};
    assign unrecoverable = st_ff.sys_lock;
    assign servo_active  = st_ff.servo;
    assign servo_free    = ~st_ff.servo;
    assign rd_code       = st_ff.rd_code;
    assign err_count     = st_ff.cnt;

    ////////////////////////////////////////////////////////////////////
    sequence s_amp_clean;
        amp_valid && !sys_fault && !amp_link_lost;
    endsequence

    sequence s_quiet0;
        !sys_fault && !amp_valid && !err_valid && !amp_link_lost;
    endsequence

    property p_sys_halt;
        @(posedge ref_clk) disable iff (!rstn)
        sys_fault |=> (&axis_halt) && (&servo_free);
    endproperty
    a_sys_halt: assert property (p_sys_halt)
        else $error("system fault did not halt all axes");

    property p_clear;
        @(posedge ref_clk) disable iff (!rstn)
        s_quiet0 and (err_clr_req[0] && !axis_locked[0])
        |=> !axis_error[0];
    endproperty
    a_clear: assert property (p_clear)
        else $error("recoverable error not cleared");

    property p_locked;
        @(posedge ref_clk) disable iff (!rstn)
        unrecoverable && (&err_clr_req)
        |=> unrecoverable && (&axis_error);
    endproperty
    a_locked: assert property (p_locked)
        else $error("clear left the unrecoverable state");

    property p_amp_report;
        @(posedge ref_clk) disable iff (!rstn)
        s_amp_clean |=> axis_error[$past(amp_axis)]
            && !servo_active[$past(amp_axis)]
            && st_ff.log[$past(amp_axis)][0][31:16] == 16'h00FF;
    endproperty
    a_amp_report: assert property (p_amp_report)
        else $error("amplifier alarm not reported or servo not freed");

    property p_code(logic [7:0] bcd, logic [15:0] hex);
        @(posedge ref_clk) disable iff (!rstn)
        s_amp_clean and (amp_main_bcd == bcd)
        |=> st_ff.log[$past(amp_axis)][0][15:0] == hex;
    endproperty
    a_code_11: assert property (p_code(8'h11, 16'h000B))
        else $error("main 11 stored wrong code");
    a_code_21: assert property (p_code(8'h21, 16'h0015))
        else $error("main 21 stored wrong code");
    a_code_24: assert property (p_code(8'h24, 16'h0018))
        else $error("main 24 stored wrong code");
    a_code_33: assert property (p_code(8'h33, 16'h0021))
        else $error("main 33 stored wrong code");

    property p_stay;
        @(posedge ref_clk) disable iff (!rstn)
        axis_error[0] && !err_clr_req[0] |=> axis_error[0] [*1]
            ##0 (servo_active[0] == $past(servo_active[0])
                 || !servo_active[0]);
    endproperty
    a_stay: assert property (p_stay)
        else $error("stopped axis left error without clear");

    property p_log_shift;
        @(posedge ref_clk) disable iff (!rstn)
        s_amp_clean and (amp_axis == AW'(0))
        |=> st_ff.log[0][1] == $past(st_ff.log[0][0])
            && st_ff.log[0][LD-1] == $past(st_ff.log[0][LD-2]);
    endproperty
    a_log_shift: assert property (p_log_shift)
        else $error("error log did not shift newest first");
endmodule

/* verification/saer_amp_model.sv */
// Networked servo amplifier that reports alarms
`timescale 1ns/10ps
module saer_amp_model (
    input  wire logic       ref_clk,
    output logic            amp_valid,
    output logic [3:0]      amp_axis,
    output logic [7:0]      amp_main_bcd,
    output logic [3:0]      amp_sub
);
    initial begin
        amp_valid = 1'b0;
        amp_axis = 4'h5;
        amp_main_bcd = 8'hA5;
        amp_sub = 4'hA;
    end
    task automatic alarm(input logic [3:0] ax, input logic [7:0] mn,
                         input logic [3:0] sb);
        @(posedge ref_clk);
        amp_valid <= 1'b1;
        amp_axis <= ax;
        amp_main_bcd <= mn;
        amp_sub <= sb;
        @(posedge ref_clk);
        // Qualifiers are stale once the strobe drops
        amp_valid <= 1'b0;
        amp_axis <= ~ax;
        amp_main_bcd <= ~mn;
        amp_sub <= ~sb;
    endtask
endmodule

/* verification/servo_amp_error_recovery_tb_top.sv */
// Self-checking bench for the servo amplifier error recovery block
`timescale 1ns/10ps
module servo_amp_error_recovery_tb_top;
    logic             ref_clk = 1'b0;
    logic             rstn = 1'b0;
    logic             amp_valid, amp_link_lost = 1'b0, sys_fault = 1'b0;
    logic [3:0]       amp_axis, amp_sub, amp_link_axis = 4'h0;
    logic [7:0]       amp_main_bcd;
    logic [15:0]      err_clr_req = 16'h0000, servo_on_req = 16'h0000;
    logic [3:0]       rd_axis = 4'h0;
    logic [2:0]       rd_slot = 3'h0;
    logic             err_valid = 1'b0;
    logic [3:0]       err_axis = 4'h0;
    logic [31:0]      err_code = 32'h0000_0000;
    logic [15:0]      servo_off_req = 16'h0000;
    logic [15:0]      axis_error, axis_halt, axis_locked;
    logic [15:0]      servo_active, servo_free;
    logic             unrecoverable;
    logic [31:0]      rd_code;
    logic [15:0][7:0] err_count;
    int               failures = 0;
    int               n_tests = 0;
    always #2 ref_clk = ~ref_clk;
    saer_amp_model u_amp (.ref_clk(ref_clk), .amp_valid(amp_valid),
        .amp_axis(amp_axis), .amp_main_bcd(amp_main_bcd), .amp_sub(amp_sub));
    saer_error_unit u_dut (.ref_clk(ref_clk), .rstn(rstn),
        .amp_valid(amp_valid), .amp_axis(amp_axis),
        .amp_main_bcd(amp_main_bcd), .amp_sub(amp_sub),
        .amp_link_lost(amp_link_lost), .amp_link_axis(amp_link_axis),
        .sys_fault(sys_fault), .err_valid(err_valid), .err_axis(err_axis),
        .err_code(err_code), .err_clr_req(err_clr_req),
        .servo_on_req(servo_on_req), .servo_off_req(servo_off_req),
        .rd_axis(rd_axis), .rd_slot(rd_slot), .axis_error(axis_error),
        .axis_halt(axis_halt), .axis_locked(axis_locked),
        .unrecoverable(unrecoverable), .servo_active(servo_active),
        .servo_free(servo_free), .rd_code(rd_code), .err_count(err_count));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_code(input logic [7:0] b);
        return saer_pkg::AMP_GROUP_BASE | ({28'h0, b[7:4]} * 32'h0000_000A
            + {28'h0, b[3:0]});
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [3:0] ax, input logic [2:0] sl,
                      output logic [31:0] v);
        @(posedge ref_clk);
        rd_axis <= ax;
        rd_slot <= sl;
        @(posedge ref_clk);
        #1;
        v = rd_code;
    endtask
    task automatic drive(input logic [15:0] clr, input logic [15:0] on,
                         input logic [4:0] lnk, input logic sf);
        @(posedge ref_clk);
        err_clr_req <= clr;
        servo_on_req <= on;
        amp_link_lost <= lnk[4];
        amp_link_axis <= lnk[3:0];
        sys_fault <= sf;
        @(posedge ref_clk);
        err_clr_req <= 16'h0000;
        servo_on_req <= 16'h0000;
        amp_link_lost <= 1'b0;
        sys_fault <= 1'b0;
        #1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end
    initial begin
        logic [31:0] v, ec, last [16];
        logic [3:0]  ax, sb;
        logic [7:0]  mn, cnt;
        logic [7:0]  tbl [6];
        logic [15:0] etbl [6];
        logic [3:0]  stbl [6];
        // Corner cases: fixed-code main numbers, two subs for 21 and 24
        tbl  = '{8'h11, 8'h21, 8'h21, 8'h24, 8'h24, 8'h33};
        etbl = '{16'h000B, 16'h0015, 16'h0015, 16'h0018, 16'h0018, 16'h0021};
        stbl = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h5};
        v = $urandom(32'hB366ADBF);
        foreach (last[i]) last[i] = 32'h0000_0000;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        chk("free", 32'h0000FFFF, {16'h0, servo_free});
        drive(16'h0000, 16'hFFFF, 5'h00, 1'b0);
        chk("on", 32'h0000FFFF, {16'h0, servo_active});
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            // Axis 0 first so the log shift and clear checks see traffic
            ax = (i == 0) ? 4'h0 : 4'($urandom_range(13));
            mn = (i < 6) ? tbl[i] :
                 {4'($urandom_range(9)), 4'($urandom_range(9))};
            sb = (i < 6) ? stbl[i] : 4'($urandom_range(15));
            cnt = err_count[ax];
            u_amp.alarm(ax, mn, sb);
            #1;
            chk("halt", 32'h1, {31'h0, axis_halt[ax]});
            chk("servo", 32'h0, {31'h0, servo_active[ax]});
            chk("count", 32'(cnt) + 32'h1, 32'(err_count[ax]));
            rd(ax, 3'h0, v);
            if (i < 6) begin
                ec = saer_pkg::AMP_GROUP_BASE | {16'h0000, etbl[i]};
                chk("code", ec, v);
            end else begin
                chk("code", exp_code(mn), v);
            end
            rd(ax, 3'h1, v);
            chk("older", last[ax], v);
            last[ax] = exp_code(mn);
            drive(16'h0001 << ax, 16'h0001 << ax, 5'h00, 1'b0);
            chk("clear", 32'h0, {31'h0, axis_error[ax]});
            chk("still off", 32'h0, {31'h0, servo_active[ax]});
            drive(16'h0000, 16'h0001 << ax, 5'h00, 1'b0);
            chk("on again", 32'h1, {31'h0, servo_active[ax]});
        end
        $display("test alarms done");
        // Nine alarms on a spare axis push the first out of the log
        for (int k = 1; k < 10; k++) begin
            u_amp.alarm(4'hF, 8'(k), 4'(k));
        end
        #1;
        chk("depth count", 32'h9, 32'(err_count[15]));
        rd(4'hF, 3'h0, v);
        chk("newest", saer_pkg::AMP_GROUP_BASE | 32'h9, v);
        rd(4'hF, 3'h7, v);
        chk("oldest", saer_pkg::AMP_GROUP_BASE | 32'h2, v);
        $display("test depth done");
        // Non-amplifier error halts but leaves the servo powered
        ec = $urandom();
        @(posedge ref_clk);
        err_valid <= 1'b1;
        err_axis <= 4'hD;
        err_code <= ec;
        @(posedge ref_clk);
        err_valid <= 1'b0;
        #1;
        chk("other halt", 32'h1, {31'h0, axis_halt[13]});
        chk("other servo", 32'h1, {31'h0, servo_active[13]});
        rd(4'hD, 3'h0, v);
        chk("other code", ec, v);
        @(posedge ref_clk);
        servo_off_req <= 16'h2000;
        servo_on_req <= 16'h2000;
        @(posedge ref_clk);
        servo_off_req <= 16'h0000;
        servo_on_req <= 16'h0000;
        #1;
        chk("off", 32'h0, {31'h0, servo_active[13]});
        drive(16'h2000, 16'h2000, 5'h00, 1'b0);
        chk("other clear", 32'h0, {31'h0, axis_error[13]});
        drive(16'h0000, 16'h2000, 5'h00, 1'b0);
        chk("other on", 32'h1, {31'h0, servo_active[13]});
        $display("test other done");
        drive(16'h0000, 16'h0000, 5'h1E, 1'b0);
        drive(16'h4000, 16'h4000, 5'h00, 1'b0);
        chk("locked", 32'h1, {31'h0, axis_locked[14]});
        chk("link err", 32'h1, {31'h0, axis_error[14]});
        $display("test link done");
        drive(16'h0000, 16'h0000, 5'h00, 1'b1);
        drive(16'hFFFF, 16'hFFFF, 5'h00, 1'b0);
        chk("unrec", 32'h1, {31'h0, unrecoverable});
        chk("all halt", 32'h0000FFFF, {16'h0, axis_halt});
        chk("all free", 32'h0000FFFF, {16'h0, servo_free});
        $display("test fault done");
        // Power cycle is the only way out of the locked state
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        chk("cycled", 32'h0, {31'h0, unrecoverable});
        chk("unlocked", 32'h0, {16'h0, axis_locked});
        u_amp.alarm(4'hE, 8'h11, 4'h0);
        drive(16'h4000, 16'h0000, 5'h00, 1'b0);
        chk("relink clear", 32'h0, {31'h0, axis_error[14]});
        $display("test power cycle done");
        end_of_test();
    end
endmodule
